// File: design/serial_bus_byte_master.v
// software-driven two-wire serial-bus master moving one byte per cycle
// assumes byte-wide config-space access strobes on clk_in and open-drain
// scl/sda pins resolved outside with pull-ups
// Operation
// - for a write, software loads the data byte before writing the target register and that byte is sent.
// - for a read, the received byte lands in the data register and is valid once busy is back to zero.
// - the word location register gives the byte position in the target and is sent during the cycle when address phase select is zero.
// - a write to the target register while idle with the interface enabled launches one serial transaction with the current register contents.
// - bits 7:1 of the target register hold the 7-bit target address, reset to zero.
// - bit 0 of the target register picks write (0, default) or read (1), one byte each cycle.
// - data, word location and target registers clear on link reset, global reset and power-on reset.
// - the busy flag is set while a software-launched cycle runs and cleared when it ends.
// - address phase select zero sends target then word location; one sends only the target address.
// - a failed cycle sets a sticky error flag that a read of the status register clears.
// - the interface enable hands the pins to the serial bus and is set when an eeprom is detected after reset.
`timescale 1ns/1ps
`default_nettype none
`include "serial_bus_regs.vh"

module serial_bus_byte_master #(
  parameter CLK_MHZ = 100
) (
  input wire clk_in,
  input wire rst_in,
  input wire fundamental_link_reset_n_in,
  input wire global_reset_pin_n_in,
  input wire eeprom_detect_in,
  input wire [7:0] cfg_addr_in,
  input wire cfg_wr_in,
  input wire cfg_rd_in,
  input wire [7:0] cfg_wdata_in,
  output reg [7:0] cfg_rdata_out,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe_n_out,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n_out
);

  // quarter-bit lengths derived from period and clock rate, rounded down
  localparam integer NORM_INT =
    (`SB_NORM_PERIOD_NS * CLK_MHZ) / (1000 * `SB_QUARTERS_PER_BIT);
  localparam integer TEST_INT =
    (`SB_TEST_PERIOD_NS * CLK_MHZ) / (1000 * `SB_QUARTERS_PER_BIT);
  localparam [8:0] Q_NORM_CYC = NORM_INT[8:0];
  localparam [8:0] Q_TEST_CYC = TEST_INT[8:0];

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_BIT = 5'h04;
  localparam [4:0] S_RSTART = 5'h08;
  localparam [4:0] S_STOP = 5'h10;

  localparam [1:0] K_ADDR = 2'h0;
  localparam [1:0] K_WORD = 2'h1;
  localparam [1:0] K_RADDR = 2'h2;
  localparam [1:0] K_DATA = 2'h3;

  wire [4:0] sync_w;
  wire scl_sync = sync_w[0];
  wire sda_sync = sync_w[1];
  wire detect_sync = sync_w[4];
  // any of the three resets clears the block
  wire rst_all = rst_in | ~sync_w[2] | ~sync_w[3];

  sync_2ff #(.WIDTH(5)) pin_sync (
    .clk_in(clk_in),
    .async_in({eeprom_detect_in, global_reset_pin_n_in,
               fundamental_link_reset_n_in, sda_in, scl_in}),
    .sync_out(sync_w)
  );

  reg [7:0] data_reg, data_next;
  reg [7:0] word_reg;
  reg [7:0] target_reg;
  reg phase_sel_reg, enable_reg, test_reg, error_reg, error_next;
  reg detect_done_reg;
  reg [4:0] state_reg, state_next;
  reg [1:0] kind_reg, kind_next;
  reg [1:0] q_reg;
  reg [3:0] bit_reg, bit_next;
  reg [8:0] div_reg;
  reg [7:0] shift_reg, shift_next;
  reg scl_low_reg, scl_low_next, sda_low_reg, sda_low_next;

  wire busy = ~state_reg[0];
  wire is_read = target_reg[`SB_TGT_DIR] == `SB_DIR_READ;
  wire hit_wr_target = cfg_wr_in && cfg_addr_in == `SB_OFS_TARGET;
  wire hit_rd_ctrl = cfg_rd_in && cfg_addr_in == `SB_OFS_CTRL;
  // launch only when idle and the pins belong to the serial bus
  wire launch = hit_wr_target && !busy && enable_reg;
  wire [8:0] q_len = test_reg ? Q_TEST_CYC : Q_NORM_CYC;
  // hold the high phase while a target stretches scl low
  wire stretched = !scl_low_reg && !scl_sync;
  wire tick = busy && div_reg == q_len - 9'h001 && !stretched;
  wire last_q = tick && q_reg == 2'h3;
  wire rx_byte = kind_reg == K_DATA && is_read;

  // byte loaded for each phase of the cycle
  function [7:0] byte_for;
    input [1:0] kind;
    begin
      case (kind)
        K_ADDR: byte_for = {target_reg[`SB_TGT_ADDR_HI:`SB_TGT_ADDR_LO],
                   phase_sel_reg ? target_reg[`SB_TGT_DIR]
                                 : `SB_DIR_WRITE};
        K_WORD: byte_for = word_reg;
        K_RADDR: byte_for = {target_reg[`SB_TGT_ADDR_HI:`SB_TGT_ADDR_LO],
                   `SB_DIR_READ};
        default: byte_for = data_reg;
      endcase
    end
  endfunction

  // quarter-bit divider and quarter counter
  always @(posedge clk_in) begin
    if (rst_all || !busy) begin
      div_reg <= 9'h000;
      q_reg <= 2'h0;
    end else if (tick) begin
      div_reg <= 9'h000;
      q_reg <= q_reg + 2'h1;
    end else if (!stretched || div_reg != q_len - 9'h001) begin
      div_reg <= div_reg + 9'h001;
    end
  end

  // sequencer: pin levels per quarter and byte-phase stepping
  always @* begin
    state_next = state_reg;
    kind_next = kind_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    scl_low_next = scl_low_reg;
    sda_low_next = sda_low_reg;
    data_next = data_reg;
    error_next = 1'b0;
    case (state_reg)
      S_IDLE: begin
        scl_low_next = 1'b0;
        sda_low_next = 1'b0;
        if (launch) begin
          state_next = S_START;
          kind_next = K_ADDR;
        end
      end
      S_START, S_RSTART: begin
        // sda falls while scl is high, then scl goes low
        if (tick) begin
          case (q_reg)
            2'h0: begin
              scl_low_next = state_reg[3];
              sda_low_next = 1'b0;
            end
            2'h1: scl_low_next = 1'b0;
            2'h2: sda_low_next = 1'b1;
            default: begin
              scl_low_next = 1'b1;
              state_next = S_BIT;
              bit_next = `SB_BIT_FIRST;
              shift_next = byte_for(kind_reg);
            end
          endcase
        end
      end
      S_BIT: begin
        if (tick) begin
          case (q_reg)
            2'h0: begin
              scl_low_next = 1'b1;
              // receiver releases data bits; master nacks the read byte
              if (bit_reg == `SB_ACK_BIT)
                sda_low_next = rx_byte ? 1'b0 : 1'b0;
              else
                sda_low_next = rx_byte ? 1'b0 : ~shift_reg[7];
            end
            2'h1: scl_low_next = 1'b0;
            2'h2: scl_low_next = 1'b0;
            default: begin
              scl_low_next = 1'b1;
              if (bit_reg != `SB_ACK_BIT) begin
                shift_next = {shift_reg[6:0], sda_sync};
                bit_next = bit_reg + 4'h1;
              end else if (!rx_byte && sda_sync) begin
                error_next = 1'b1;
                state_next = S_STOP;
              end else begin
                bit_next = `SB_BIT_FIRST;
                case (kind_reg)
                  K_ADDR: begin
                    state_next = S_BIT;
                    kind_next = phase_sel_reg ? K_DATA : K_WORD;
                    shift_next = byte_for(phase_sel_reg ? K_DATA : K_WORD);
                  end
                  K_WORD: begin
                    if (is_read) begin
                      state_next = S_RSTART;
                      kind_next = K_RADDR;
                    end else begin
                      kind_next = K_DATA;
                      shift_next = byte_for(K_DATA);
                    end
                  end
                  K_RADDR: begin
                    kind_next = K_DATA;
                    shift_next = byte_for(K_DATA);
                  end
                  default: begin
                    if (rx_byte)
                      data_next = shift_reg;
                    state_next = S_STOP;
                  end
                endcase
              end
            end
          endcase
        end
      end
      S_STOP: begin
        // sda rises while scl is high
        if (tick) begin
          case (q_reg)
            2'h0: begin
              scl_low_next = 1'b1;
              sda_low_next = 1'b1;
            end
            2'h1: scl_low_next = 1'b0;
            2'h2: sda_low_next = 1'b0;
            default: state_next = S_IDLE;
          endcase
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // sequencer state
  always @(posedge clk_in) begin
    if (rst_all) begin
      state_reg <= S_IDLE;
      kind_reg <= K_ADDR;
      bit_reg <= `SB_BIT_FIRST;
      shift_reg <= `SB_RST_BYTE;
      scl_low_reg <= `SB_RST_BIT;
      sda_low_reg <= `SB_RST_BIT;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
    end
  end

  // software registers; a received byte that differs from data_reg beats a same-cycle software write
  always @(posedge clk_in) begin
    if (rst_all) begin
      data_reg <= `SB_RST_BYTE;
      word_reg <= `SB_RST_BYTE;
      target_reg <= `SB_RST_BYTE;
      phase_sel_reg <= `SB_RST_BIT;
      enable_reg <= `SB_RST_BIT;
      test_reg <= `SB_RST_BIT;
      error_reg <= `SB_RST_BIT;
      detect_done_reg <= `SB_RST_BIT;
    end else begin
      if (data_next != data_reg)
        data_reg <= data_next;
      else if (cfg_wr_in && cfg_addr_in == `SB_OFS_DATA)
        data_reg <= cfg_wdata_in;
      if (cfg_wr_in && cfg_addr_in == `SB_OFS_WORD)
        word_reg <= cfg_wdata_in;
      // target writes while busy are dropped so the cycle stays coherent
      if (hit_wr_target && !busy)
        target_reg <= cfg_wdata_in;
      // strap sampled once, after the reset is gone
      detect_done_reg <= 1'b1;
      if (!detect_done_reg && detect_sync)
        enable_reg <= 1'b1;
      else if (cfg_wr_in && cfg_addr_in == `SB_OFS_CTRL)
        enable_reg <= cfg_wdata_in[`SB_CTL_ENABLE];
      if (cfg_wr_in && cfg_addr_in == `SB_OFS_CTRL) begin
        phase_sel_reg <= cfg_wdata_in[`SB_CTL_PHASE_SEL];
        test_reg <= cfg_wdata_in[`SB_CTL_TEST];
      end
      // set wins over the read-clear
      if (error_next)
        error_reg <= 1'b1;
      else if (hit_rd_ctrl)
        error_reg <= 1'b0;
    end
  end

  // registered read data, zero for unmapped offsets
  always @(posedge clk_in) begin
    if (rst_all) begin
      cfg_rdata_out <= `SB_RST_BYTE;
    end else if (cfg_rd_in) begin
      case (cfg_addr_in)
        `SB_OFS_DATA: cfg_rdata_out <= data_reg;
        `SB_OFS_WORD: cfg_rdata_out <= word_reg;
        `SB_OFS_TARGET: cfg_rdata_out <= target_reg;
        `SB_OFS_CTRL: cfg_rdata_out <= {phase_sel_reg, 1'b0, busy, 1'b0,
                                        enable_reg, test_reg, error_reg,
                                        1'b0};
        default: cfg_rdata_out <= `SB_RST_BYTE;
      endcase
    end
  end

  // open drain: drive low only, pins released while interface disabled
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n_out = ~(scl_low_reg & enable_reg);
  assign sda_oe_n_out = ~(sda_low_reg & enable_reg);

endmodule // serial_bus_byte_master

`default_nettype wire

// File: design/serial_bus_regs.vh
// register offsets, field positions, reset values and timing constants
// for the two-wire serial-bus byte master; definitions only
`ifndef SERIAL_BUS_REGS_VH
`define SERIAL_BUS_REGS_VH

// configuration-space byte offsets
`define SB_OFS_DATA 8'hb0
`define SB_OFS_WORD 8'hb1
`define SB_OFS_TARGET 8'hb2
`define SB_OFS_CTRL 8'hb3

// reset values
`define SB_RST_BYTE 8'h00
`define SB_RST_BIT 1'b0

// target register fields
`define SB_TGT_ADDR_HI 7
`define SB_TGT_ADDR_LO 1
`define SB_TGT_DIR 0

// control/status fields
`define SB_CTL_PHASE_SEL 7
`define SB_CTL_BUSY 5
`define SB_CTL_ENABLE 3
`define SB_CTL_TEST 2
`define SB_CTL_ERROR 1

// direction codes
`define SB_DIR_WRITE 1'b0
`define SB_DIR_READ 1'b1

// serial clock period in ns, normal and test speed
`define SB_NORM_PERIOD_NS 16667
`define SB_TEST_PERIOD_NS 250
`define SB_QUARTERS_PER_BIT 4

// bit counter: eight data bits then one acknowledge bit
`define SB_ACK_BIT 4'h8
`define SB_BIT_FIRST 4'h0

`endif

// File: design/sync_2ff.v
// two-flip-flop synchroniser for levels from outside the clock domain
// assumes the inputs are levels that stay put for several clock cycles
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge clk_in) begin
    meta_reg <= async_in;
    sync_reg <= meta_reg;
  end

  assign sync_out = sync_reg;

endmodule // sync_2ff

`default_nettype wire

// File: tb/eeprom_model.sv
// behavioural two-wire target: 256-byte store and a word pointer
// assumes the bench resolves sda from both open-drain parties
`timescale 1ns/1ps
`default_nettype none
module eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_drv_n_out
);
  logic [7:0] mem [0:255];
  logic [7:0] ptr, sh;
  logic active, first, rd, ack, wp;
  int bitn;
  initial begin
    sda_drv_n_out = 1'b1;
    active = 1'b0;
    ptr = 8'h00;
  end
  // start or repeated start
  always @(negedge sda_in) if (scl_in) begin
    active = 1'b1;
    first = 1'b1;
    bitn = 0;
  end
  always @(posedge sda_in) if (scl_in) active = 1'b0;
  // msb first on rising scl; no shift while sending
  always @(posedge scl_in) if (active && bitn < 8) begin
    if (!rd || first) sh = {sh[6:0], sda_in};
    bitn = bitn + 1;
  end
  // all pin changes while scl is low, so no false start or stop
  always @(negedge scl_in) if (active) begin
    if (bitn == 8) begin
      if (first) begin
        ack = sh[7:1] == DEV_ADDR;
        rd = sh[0];
        wp = 1'b1;
        first = 1'b0;
      end else if (rd) begin
        ack = 1'b0;
        ptr = ptr + 8'h01;
      end else if (wp) begin
        ptr = sh;
        wp = 1'b0;
      end else begin
        mem[ptr] = sh;
        ptr = ptr + 8'h01;
      end
      sda_drv_n_out = !ack;
      bitn = 9;
    end else if (bitn == 9) begin
      bitn = 0;
      sh = mem[ptr];
      sda_drv_n_out = !(rd && ack) || sh[7];
    end else if (rd && ack) sda_drv_n_out = sh[7 - bitn];
  end
endmodule // eeprom_model
`default_nettype wire

// File: tb/sb_sva.sv
// port checker for the serial-bus byte master
// assumes test speed is set whenever a launch is to be judged
`timescale 1ns/1ps
`default_nettype none
module sb_sva (
  input wire clk_in,
  input wire rst_in,
  input wire fundamental_link_reset_n_in,
  input wire global_reset_pin_n_in,
  input wire [7:0] cfg_addr_in,
  input wire cfg_wr_in,
  input wire cfg_rd_in,
  input wire [7:0] cfg_wdata_in,
  input wire [7:0] cfg_rdata_out,
  input wire scl_out,
  input wire scl_oe_n_out,
  input wire sda_out,
  input wire sda_oe_n_out
);
  logic [1:0] ctl_m;
  logic [5:0] quiet;
  wire any_rst = rst_in | ~fundamental_link_reset_n_in |
    ~global_reset_pin_n_in;
  wire wr_tgt = cfg_wr_in && cfg_addr_in == 8'hb2;
  // enable and test bits; strap ignored, so fewer launches are judged
  always @(posedge clk_in) begin
    if (any_rst) ctl_m <= 2'h0;
    else if (cfg_wr_in && cfg_addr_in == 8'hb3) ctl_m <= cfg_wdata_in[3:2];
  end
  // cycles since scl was last pulled low; 30 means no cycle runs
  always @(posedge clk_in) begin
    if (any_rst || !scl_oe_n_out) quiet <= 6'h00;
    else if (quiet != 6'h3f) quiet <= quiet + 6'h01;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (any_rst);
  property p_rst_rdata;
    disable iff (1'b0) rst_in |=> cfg_rdata_out == 8'h00;
  endproperty
  a_rst_rdata: assert property (p_rst_rdata) else $error("rdata not 00");
  property p_rst_pins;
    disable iff (1'b0) rst_in |=> scl_oe_n_out && sda_oe_n_out;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins driven");
  property p_open_drain;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin high");
  property p_launch;
    wr_tgt && ctl_m == 2'h3 && quiet >= 6'h1e |-> ##[1:40] !sda_oe_n_out;
  endproperty
  a_launch: assert property (p_launch) else $error("no start");
  property p_rd_hold;
    !cfg_rd_in |=> $stable(cfg_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_word_rb;
    cfg_wr_in && cfg_addr_in == 8'hb1 ##1 !cfg_wr_in ##1
      cfg_rd_in && cfg_addr_in == 8'hb1 |=>
      cfg_rdata_out == $past(cfg_wdata_in, 3);
  endproperty
  a_word_rb: assert property (p_word_rb) else $error("word lost");
  property p_data_rb;
    cfg_wr_in && cfg_addr_in == 8'hb0 && quiet >= 6'h1e ##1 !cfg_wr_in ##1
      cfg_rd_in && cfg_addr_in == 8'hb0 |=>
      cfg_rdata_out == $past(cfg_wdata_in, 3);
  endproperty
  a_data_rb: assert property (p_data_rb) else $error("data lost");
  property p_tgt_rb;
    wr_tgt && ctl_m[1] && quiet >= 6'h1e ##1 !cfg_wr_in ##1
      cfg_rd_in && cfg_addr_in == 8'hb2 |=>
      cfg_rdata_out == $past(cfg_wdata_in, 3);
  endproperty
  a_tgt_rb: assert property (p_tgt_rb) else $error("target lost");
  c_launch: cover property (wr_tgt && ctl_m == 2'h3);
  c_unmapped: cover property (cfg_rd_in && cfg_addr_in == 8'hb4);
  c_error: cover property (cfg_rd_in && cfg_addr_in == 8'hb3 ##1
    cfg_rdata_out[1]);
endmodule // sb_sva
bind serial_bus_byte_master sb_sva chk (.clk_in, .rst_in,
  .fundamental_link_reset_n_in, .global_reset_pin_n_in, .cfg_addr_in,
  .cfg_wr_in, .cfg_rd_in, .cfg_wdata_in, .cfg_rdata_out, .scl_out,
  .scl_oe_n_out, .sda_out, .sda_oe_n_out);
`default_nettype wire

// File: tb/tb_top.sv
// bench: byte accesses on the config strobes, pull-up pins, one target
// assumes the target answers at address 7'h50 and test speed is used
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic link_n = 1'b1;
  logic glob_n = 1'b1;
  logic strap = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic busy_seen, err_seen;
  logic [7:0] rv;
  wire [7:0] rdata;
  wire scl_oe_n, sda_oe_n, sda_drv_n;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  // open-drain wires with pull-ups
  wire scl = scl_oe_n;
  wire sda = sda_oe_n & sda_drv_n;
  serial_bus_byte_master uut (.clk_in(clk_in), .rst_in(rst_in),
    .fundamental_link_reset_n_in(link_n), .global_reset_pin_n_in(glob_n),
    .eeprom_detect_in(strap), .cfg_addr_in(addr), .cfg_wr_in(wr),
    .cfg_rd_in(rd), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata),
    .scl_in(scl), .scl_out(), .scl_oe_n_out(scl_oe_n), .sda_in(sda),
    .sda_out(), .sda_oe_n_out(sda_oe_n));
  eeprom_model model (.scl_in(scl), .sda_in(sda), .sda_drv_n_out(sda_drv_n));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      end_sim;
    end
  end
  task automatic end_sim;
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one strobe cycle; read data taken after the strobe edge
  task automatic acc(input logic w, input logic [7:0] a, d,
    output logic [7:0] q);
    @(posedge clk_in);
    #1;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(posedge clk_in);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    q = rdata;
  endtask
  // polls status; the poll also clears the error flag, so keep it
  task automatic wait_idle;
    busy_seen = 1'b0;
    err_seen = 1'b0;
    for (int i = 0; i < 1500; i++) begin
      acc(1'b0, 8'hb3, 8'h00, rv);
      err_seen = err_seen | rv[1];
      if (rv[5] !== 1'b1) break;
      busy_seen = 1'b1;
    end
    // a cycle that never ends must not pass as idle
    check("idle", {7'h00, rv[5]}, 8'h00);
  endtask
  task automatic xfer(input logic [7:0] ctl, word, data, tgt);
    acc(1'b1, 8'hb3, ctl, rv);
    acc(1'b1, 8'hb1, word, rv);
    acc(1'b1, 8'hb0, data, rv);
    acc(1'b1, 8'hb2, tgt, rv);
    wait_idle;
  endtask
  task automatic t_reset_vals;
    for (int a = 8'hb0; a <= 8'hb4; a++) begin
      acc(1'b0, a[7:0], 8'h00, rv);
      check("reset value", rv, 8'h00);
    end
  endtask
  task automatic t_disabled;
    xfer(8'h04, 8'h10, 8'h5a, 8'ha0);
    check("busy", {7'h00, busy_seen}, 8'h00);
    acc(1'b0, 8'hb2, 8'h00, rv);
    // the register keeps the byte; only the launch is withheld
    check("kept target", rv, 8'ha0);
  endtask
  task automatic t_write;
    xfer(8'h0c, 8'h10, 8'ha5, 8'ha0);
    check("busy", {7'h00, busy_seen}, 8'h01);
    check("error", {7'h00, err_seen}, 8'h00);
    check("stored", model.mem[8'h10], 8'ha5);
  endtask
  task automatic t_read;
    acc(1'b1, 8'hb1, 8'h10, rv);
    acc(1'b0, 8'hb1, 8'h00, rv);
    check("word", rv, 8'h10);
    acc(1'b1, 8'hb0, 8'h00, rv);
    acc(1'b0, 8'hb0, 8'h00, rv);
    check("data", rv, 8'h00);
    acc(1'b1, 8'hb2, 8'ha1, rv);
    acc(1'b0, 8'hb2, 8'h00, rv);
    check("target", rv, 8'ha1);
    wait_idle;
    acc(1'b0, 8'hb0, 8'h00, rv);
    check("read byte", rv, 8'ha5);
  endtask
  // current-address read: pointer sits one past the last read
  task automatic t_psel;
    model.mem[8'h11] = 8'h3c;
    xfer(8'h8c, 8'h77, 8'h00, 8'ha1);
    acc(1'b0, 8'hb0, 8'h00, rv);
    check("short read", rv, 8'h3c);
  endtask
  task automatic t_nack;
    xfer(8'h0c, 8'h01, 8'h02, 8'h46);
    check("error", {7'h00, err_seen}, 8'h01);
    acc(1'b0, 8'hb3, 8'h00, rv);
    check("error cleared", rv & 8'h22, 8'h00);
  endtask
  task automatic t_pin_reset;
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 8'hb0, 8'h77, rv);
      acc(1'b1, 8'hb1, 8'h88, rv);
      link_n = i[0];
      glob_n = !i[0];
      repeat (4) @(posedge clk_in);
      #1;
      link_n = 1'b1;
      glob_n = 1'b1;
      repeat (4) @(posedge clk_in);
      t_reset_vals;
    end
  endtask
  // strap held through a mid-run reset must hand the pins to the bus
  task automatic t_strap;
    strap = 1'b1;
    rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    acc(1'b0, 8'hb3, 8'h00, rv);
    check("strap enable", rv, 8'h08);
    strap = 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    t_reset_vals;
    t_disabled;
    t_write;
    t_read;
    t_psel;
    t_nack;
    t_pin_reset;
    t_strap;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
